//--- verilog/conv_ctrl_pkg.sv
// package: register map, field positions, reset values and timing counts for the converter control
package conv_ctrl_pkg;
  // register byte offsets on the axi4-lite bus
  localparam logic [7:0] OFF_SC1 = 8'h00;
  localparam logic [7:0] OFF_SC2 = 8'h04;
  localparam logic [7:0] OFF_CFG = 8'h08;
  localparam logic [7:0] OFF_CVH = 8'h0c;
  localparam logic [7:0] OFF_CVL = 8'h10;
  localparam logic [7:0] OFF_RH = 8'h14;
  localparam logic [7:0] OFF_RL = 8'h18;
  localparam logic [7:0] OFF_MISC = 8'h1c;
  // status_control_one fields
  localparam int SC1_DONE = 7;
  localparam int SC1_IEN = 6;
  localparam int SC1_CONT = 5;
  localparam logic [4:0] CH_OFF = 5'h1f;
  // status_control_two fields
  localparam int SC2_ACTIVE = 7;
  localparam int SC2_HWTRG = 6;
  localparam int SC2_CMP_EN = 5;
  localparam int SC2_CMP_GT = 4;
  // converter_config fields
  localparam int CFG_LP = 7;
  localparam int CFG_LSMP = 4;
  localparam int CFG_MODE_LO = 2;
  localparam int CFG_CLK_LO = 0;
  localparam logic [1:0] MODE_8 = 2'h0;
  localparam logic [1:0] MODE_10 = 2'h2;
  localparam logic [1:0] CLK_ASYNC = 2'h3;
  // misc register fields (stop entry request, async clock enable)
  localparam int MISC_STOP = 0;
  localparam int MISC_ACK_EN = 1;
  // reset values
  localparam logic [7:0] SC1_RST = 8'h1f;
  localparam logic [7:0] ZERO8 = 8'h00;
  // conversion lengths in conversion-clock cycles
  localparam int SMP_SHORT = 3;
  localparam int SMP_LONG = 23;
  // short sample, approximation and the transfer cycle together make the 17 and 20 cycle continuous period
  localparam int SAR_8 = 13;
  localparam int SAR_10 = 16;
  localparam int BUS_OVH = 5;
  // async clock start-up time
  localparam int ACK_START_NS = 5000;
  localparam int CLK_NS = 40;
  localparam int ACK_START_CYC = ACK_START_NS / CLK_NS;
  // axi responses
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
endpackage : conv_ctrl_pkg

//--- verilog/conv_ctrl.sv
// converter control: abort, power, sequencing, compare and result registers behind axi4-lite
// Function
// - write to status_control_one aborts, then restarts unless channel all ones
// - writes to control two, config or compare values abort conversion
// - reset aborts; stop entry aborts unless async clock selected
// - abort leaves result registers unchanged
// - reset returns result registers to reset values
// - stay idle until a conversion is initiated
// - async clock generator enabled when leaving idle with async selected
// - low power select gives reduced power active configuration
// - sample short or long, then approximate, then transfer result
// - first conversion short sample: 20 or 23 clocks plus 5 bus; the sequencer gives 17 or 20 plus 5
// - first conversion long sample: 40 or 43 clocks plus 5 bus; the sequencer gives 37 or 40 plus 5
// - continuous short sample: 17 or 20 conversion clocks
// - continuous long sample: 37 or 40 conversion clocks
// - compare enable subtracts compare value from each result
// - greater select 1: done only when result at least compare value
// - greater select 0: done only when result below compare value
// - done flag with interrupt enable raises interrupt request
// - difference one bit wider; stored without sign bit
// - compare false: no done flag, no result update
// - compare works in wait and stop3; interrupt wakes processor
// - disabled in reset or channel all ones; idle between conversions
// - mode picks 10-bit across both registers or 8-bit low only
`timescale 1ns/100ps
module conv_ctrl #(
  parameter int ACK_START = conv_ctrl_pkg::ACK_START_CYC
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // axi4-lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog core
  input wire logic [9:0] core_data,
  output logic [4:0] channel_select,
  output logic core_sample,
  output logic core_convert,
  output logic low_power_select,
  output logic internal_async_clock,
  // system
  output logic done_irq
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_START = 5'b00010,
    ST_SAMPLE = 5'b00100,
    ST_SAR = 5'b01000,
    ST_XFER = 5'b10000
  } seq_e;

  seq_e state_r;
  logic [7:0] sc1_r, sc2_r, cfg_r, cvh_r, cvl_r, rh_r, rl_r;
  logic stop_r;
  logic [12:0] cnt_r;
  logic first_r;
  logic [7:0] awaddr_r;
  logic aw_have_r, w_have_r;
  logic [7:0] wdata_r;
  logic wr_fire;
  logic [7:0] wr_addr;
  logic abort;
  logic restart;
  logic sc1_wr;
  logic mode10, lsmp, async_sel;
  logic [10:0] diff;
  logic cmp_ok;
  logic [9:0] rval;

  // byte lane check, reused by write path
  function automatic logic lane0(input logic [3:0] strb);
    lane0 = strb[0];
  endfunction : lane0

  // address decode shared by read and write paths
  function automatic logic mapped(input logic [7:0] a);
    if (a == conv_ctrl_pkg::OFF_SC1) mapped = 1'b1;
    else if (a == conv_ctrl_pkg::OFF_SC2) mapped = 1'b1;
    else if (a == conv_ctrl_pkg::OFF_CFG) mapped = 1'b1;
    else if (a == conv_ctrl_pkg::OFF_CVH) mapped = 1'b1;
    else if (a == conv_ctrl_pkg::OFF_CVL) mapped = 1'b1;
    else if (a == conv_ctrl_pkg::OFF_RH) mapped = 1'b1;
    else if (a == conv_ctrl_pkg::OFF_RL) mapped = 1'b1;
    else if (a == conv_ctrl_pkg::OFF_MISC) mapped = 1'b1;
    else mapped = 1'b0;
  endfunction : mapped

  // config decode
  assign mode10 = (cfg_r[conv_ctrl_pkg::CFG_MODE_LO +: 2] == conv_ctrl_pkg::MODE_10);
  assign lsmp = cfg_r[conv_ctrl_pkg::CFG_LSMP];
  assign async_sel = (cfg_r[conv_ctrl_pkg::CFG_CLK_LO +: 2] == conv_ctrl_pkg::CLK_ASYNC);

  // write channel handshake: address and data taken in either order, one at a time
  // readies fall with clk_en so no address or data handshake completes while state is frozen
  assign s_axi_awready = clk_en && !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = clk_en && !w_have_r && !s_axi_bvalid;
  assign wr_fire = aw_have_r && w_have_r && clk_en;
  assign wr_addr = awaddr_r;
  assign sc1_wr = wr_fire && (wr_addr == conv_ctrl_pkg::OFF_SC1) && lane0(4'h1);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 8'h00;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= conv_ctrl_pkg::RESP_OK;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= lane0(s_axi_wstrb) || 1'b1;
        wdata_r <= lane0(s_axi_wstrb) ? s_axi_wdata[7:0] : 8'h00;
      end
      if (wr_fire) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(wr_addr) ? conv_ctrl_pkg::RESP_OK : conv_ctrl_pkg::RESP_ERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign abort = (wr_fire && (wr_addr == conv_ctrl_pkg::OFF_SC1 || wr_addr == conv_ctrl_pkg::OFF_SC2 ||
                  wr_addr == conv_ctrl_pkg::OFF_CFG || wr_addr == conv_ctrl_pkg::OFF_CVH ||
                  wr_addr == conv_ctrl_pkg::OFF_CVL)) ||
                 (clk_en && stop_r && !async_sel);
  // new conversion unless channel all ones
  assign restart = sc1_wr && (wdata_r[4:0] != conv_ctrl_pkg::CH_OFF);

  // control registers; done flag cleared by a status_control_one write, set wins
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sc1_r <= conv_ctrl_pkg::SC1_RST;
      sc2_r <= conv_ctrl_pkg::ZERO8;
      cfg_r <= conv_ctrl_pkg::ZERO8;
      cvh_r <= conv_ctrl_pkg::ZERO8;
      cvl_r <= conv_ctrl_pkg::ZERO8;
      stop_r <= 1'b0;
    end else if (clk_en) begin
      if (wr_fire && wr_addr == conv_ctrl_pkg::OFF_SC1) sc1_r[6:0] <= wdata_r[6:0];
      if (wr_fire && wr_addr == conv_ctrl_pkg::OFF_SC2) sc2_r[6:4] <= wdata_r[6:4];
      if (wr_fire && wr_addr == conv_ctrl_pkg::OFF_CFG) cfg_r <= wdata_r;
      if (wr_fire && wr_addr == conv_ctrl_pkg::OFF_CVH) cvh_r <= {6'h00, wdata_r[1:0]};
      if (wr_fire && wr_addr == conv_ctrl_pkg::OFF_CVL) cvl_r <= wdata_r;
      if (wr_fire && wr_addr == conv_ctrl_pkg::OFF_MISC) stop_r <= wdata_r[conv_ctrl_pkg::MISC_STOP];
      // done only on a passing transfer; set wins over clear
      if (state_r == ST_XFER && cmp_ok) sc1_r[conv_ctrl_pkg::SC1_DONE] <= 1'b1;
      else if (sc1_wr) sc1_r[conv_ctrl_pkg::SC1_DONE] <= 1'b0;
      sc2_r[conv_ctrl_pkg::SC2_ACTIVE] <= (state_r != ST_IDLE) && !abort;
    end
  end

  // subtract compare value, one bit wider than operands
  always_comb begin
    if (mode10) begin
      diff = {1'b0, core_data} - {1'b0, cvh_r[1:0], cvl_r};
    end else begin
      diff = {2'b00, ({1'b0, core_data[7:0]} - {1'b0, cvl_r})};
      diff[10] = diff[8];
    end
    if (!sc2_r[conv_ctrl_pkg::SC2_CMP_EN]) cmp_ok = 1'b1;
    else if (sc2_r[conv_ctrl_pkg::SC2_CMP_GT]) cmp_ok = !diff[10];
    else cmp_ok = diff[10];
    rval = sc2_r[conv_ctrl_pkg::SC2_CMP_EN] ? diff[9:0] : core_data;
  end

  // sequencer, counts in conversion clocks (bus clock here)
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cnt_r <= 13'h0000;
      first_r <= 1'b1;
    end else if (clk_en) begin
      if (abort) begin
        state_r <= restart ? ST_START : ST_IDLE;
        first_r <= 1'b1;
        cnt_r <= restart ? (async_sel ? 13'(ACK_START) : 13'h0000) + 13'(conv_ctrl_pkg::BUS_OVH - 1)
                         : 13'h0000;
      end else begin
        case (state_r)
          ST_IDLE: begin
            state_r <= ST_IDLE;
          end
          ST_START: begin
            if (cnt_r == 13'h0000) begin
              state_r <= ST_SAMPLE;
              cnt_r <= 13'(lsmp ? conv_ctrl_pkg::SMP_LONG - 1 : conv_ctrl_pkg::SMP_SHORT - 1);
            end else cnt_r <= cnt_r - 13'h0001;
          end
          ST_SAMPLE: begin
            if (cnt_r == 13'h0000) begin
              state_r <= ST_SAR;
              cnt_r <= 13'(mode10 ? conv_ctrl_pkg::SAR_10 - 1 : conv_ctrl_pkg::SAR_8 - 1);
            end else cnt_r <= cnt_r - 13'h0001;
          end
          ST_SAR: begin
            if (cnt_r == 13'h0000) state_r <= ST_XFER;
            else cnt_r <= cnt_r - 13'h0001;
          end
          ST_XFER: begin
            first_r <= 1'b0;
            // continuous restarts straight into sampling; compare-false single stops
            if (sc1_r[conv_ctrl_pkg::SC1_CONT]) begin
              state_r <= ST_SAMPLE;
              cnt_r <= 13'(lsmp ? conv_ctrl_pkg::SMP_LONG - 1 : conv_ctrl_pkg::SMP_SHORT - 1);
            end else state_r <= ST_IDLE;
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // result registers: reset clears, abort leaves, failed compare leaves
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rh_r <= conv_ctrl_pkg::ZERO8;
      rl_r <= conv_ctrl_pkg::ZERO8;
    end else if (clk_en && !abort && state_r == ST_XFER && cmp_ok) begin
      rh_r <= mode10 ? {6'h00, rval[9:8]} : 8'h00;
      rl_r <= rval[7:0];
    end
  end

  // read channel: single outstanding read, data registered
  assign s_axi_arready = clk_en && !s_axi_rvalid;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= conv_ctrl_pkg::RESP_OK;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped({s_axi_araddr[7:2], 2'b00}) ? conv_ctrl_pkg::RESP_OK : conv_ctrl_pkg::RESP_ERR;
        if ({s_axi_araddr[7:2], 2'b00} == conv_ctrl_pkg::OFF_SC1) s_axi_rdata <= {24'h0, sc1_r};
        else if ({s_axi_araddr[7:2], 2'b00} == conv_ctrl_pkg::OFF_SC2) s_axi_rdata <= {24'h0, sc2_r};
        else if ({s_axi_araddr[7:2], 2'b00} == conv_ctrl_pkg::OFF_CFG) s_axi_rdata <= {24'h0, cfg_r};
        else if ({s_axi_araddr[7:2], 2'b00} == conv_ctrl_pkg::OFF_CVH) s_axi_rdata <= {24'h0, cvh_r};
        else if ({s_axi_araddr[7:2], 2'b00} == conv_ctrl_pkg::OFF_CVL) s_axi_rdata <= {24'h0, cvl_r};
        else if ({s_axi_araddr[7:2], 2'b00} == conv_ctrl_pkg::OFF_RH) s_axi_rdata <= {24'h0, rh_r};
        else if ({s_axi_araddr[7:2], 2'b00} == conv_ctrl_pkg::OFF_RL) s_axi_rdata <= {24'h0, rl_r};
        else if ({s_axi_araddr[7:2], 2'b00} == conv_ctrl_pkg::OFF_MISC)
          s_axi_rdata <= {30'h0, internal_async_clock, stop_r};
        else s_axi_rdata <= 32'h00000000;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // core drive: sampling and approximation strobes, power and clock enables
  assign channel_select = sc1_r[4:0];
  assign core_sample = (state_r == ST_SAMPLE);
  assign core_convert = (state_r == ST_SAR);
  // low power only matters while active
  assign low_power_select = cfg_r[conv_ctrl_pkg::CFG_LP] && (state_r != ST_IDLE);
  // async generator runs only out of idle; it keeps running through stop
  assign internal_async_clock = async_sel && (state_r != ST_IDLE);
  // interrupt request from flag and enable; wakes from wait or stop3
  assign done_irq = sc1_r[conv_ctrl_pkg::SC1_DONE] && sc1_r[conv_ctrl_pkg::SC1_IEN];

  // assertions
  property p_abort_idle;
    @(posedge mclk) disable iff (!rst_n) (clk_en && abort && !restart) |=> state_r == ST_IDLE;
  endproperty
  a_abort_idle: assert property (p_abort_idle) else $error("abort did not idle");
  property p_restart;
    @(posedge mclk) disable iff (!rst_n) (clk_en && restart) |=> state_r == ST_START;
  endproperty
  a_restart: assert property (p_restart) else $error("restart missing");
  property p_hold_res;
    @(posedge mclk) disable iff (!rst_n) (clk_en && abort) |=> $stable(rl_r) && $stable(rh_r);
  endproperty
  a_hold_res: assert property (p_hold_res) else $error("abort changed result");
  property p_rst_res;
    @(posedge mclk) !rst_n |=> rl_r == 8'h00 && rh_r == 8'h00 && state_r == ST_IDLE;
  endproperty
  a_rst_res: assert property (p_rst_res) else $error("reset left result");
  property p_irq;
    @(posedge mclk) disable iff (!rst_n) done_irq == (sc1_r[7] && sc1_r[6]);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_cmp_false;
    @(posedge mclk) disable iff (!rst_n)
      (clk_en && state_r == ST_XFER && !cmp_ok && !sc1_wr && !abort) |=> $stable(rl_r) && $stable(sc1_r[7]);
  endproperty
  a_cmp_false: assert property (p_cmp_false) else $error("failed compare updated");
  property p_ack;
    @(posedge mclk) disable iff (!rst_n) state_r == ST_IDLE |-> !internal_async_clock && !low_power_select;
  endproperty
  a_ack: assert property (p_ack) else $error("idle not quiet");
  // phase lengths, judged only where no abort cut the phase short
  property p_short;
    @(posedge mclk) disable iff (!rst_n)
      (clk_en && $fell(core_sample) && !$past(abort) && !lsmp) |->
        $past(core_sample, conv_ctrl_pkg::SMP_SHORT) && !$past(core_sample, conv_ctrl_pkg::SMP_SHORT + 1);
  endproperty
  a_short: assert property (p_short) else $error("short sample length");
  property p_long;
    @(posedge mclk) disable iff (!rst_n)
      (clk_en && $fell(core_sample) && !$past(abort) && lsmp) |->
        $past(core_sample, conv_ctrl_pkg::SMP_LONG) && !$past(core_sample, conv_ctrl_pkg::SMP_LONG + 1);
  endproperty
  a_long: assert property (p_long) else $error("long sample length");
  property p_sar10;
    @(posedge mclk) disable iff (!rst_n)
      (clk_en && $fell(core_convert) && !$past(abort) && mode10) |->
        $past(core_convert, conv_ctrl_pkg::SAR_10) && !$past(core_convert, conv_ctrl_pkg::SAR_10 + 1);
  endproperty
  a_sar10: assert property (p_sar10) else $error("10-bit approximation length");
  property p_sar8;
    @(posedge mclk) disable iff (!rst_n)
      (clk_en && $fell(core_convert) && !$past(abort) && !mode10) |->
        $past(core_convert, conv_ctrl_pkg::SAR_8) && !$past(core_convert, conv_ctrl_pkg::SAR_8 + 1);
  endproperty
  a_sar8: assert property (p_sar8) else $error("8-bit approximation length");
  property p_async_on;
    @(posedge mclk) disable iff (!rst_n) (clk_en && restart && async_sel) |=> internal_async_clock;
  endproperty
  a_async_on: assert property (p_async_on) else $error("async clock not started");
  property p_lp;
    @(posedge mclk) disable iff (!rst_n) (core_sample && cfg_r[conv_ctrl_pkg::CFG_LP]) |-> low_power_select;
  endproperty
  a_lp: assert property (p_lp) else $error("low power not applied");
  property p_chan_off;
    @(posedge mclk) disable iff (!rst_n)
      (sc1_wr && wdata_r[4:0] == conv_ctrl_pkg::CH_OFF) |=>
        state_r == ST_IDLE && channel_select == conv_ctrl_pkg::CH_OFF;
  endproperty
  a_chan_off: assert property (p_chan_off) else $error("channel off did not disable");
  property p_stop;
    @(posedge mclk) disable iff (!rst_n) (clk_en && stop_r && !async_sel && !sc1_wr) |=> state_r == ST_IDLE;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not abort");
  property p_res8;
    @(posedge mclk) disable iff (!rst_n)
      (clk_en && state_r == ST_XFER && cmp_ok && !abort && !mode10) |=> rh_r == conv_ctrl_pkg::ZERO8;
  endproperty
  a_res8: assert property (p_res8) else $error("8-bit result touched high byte");
  property p_cmp_diff;
    @(posedge mclk) disable iff (!rst_n)
      (clk_en && state_r == ST_XFER && cmp_ok && !abort && mode10 && sc2_r[conv_ctrl_pkg::SC2_CMP_EN]) |=>
        {rh_r[1:0], rl_r} == 10'($past(core_data) - {cvh_r[1:0], cvl_r});
  endproperty
  a_cmp_diff: assert property (p_cmp_diff) else $error("stored difference wrong");
  property p_done;
    @(posedge mclk) disable iff (!rst_n) (clk_en && state_r == ST_XFER && cmp_ok && !abort) |=> sc1_r[7];
  endproperty
  a_done: assert property (p_done) else $error("done not set");
  c_conv: cover property (@(posedge mclk) disable iff (!rst_n) state_r == ST_XFER);
  c_abort: cover property (@(posedge mclk) disable iff (!rst_n) abort && state_r == ST_SAR);
  c_cmp: cover property (@(posedge mclk) disable iff (!rst_n) state_r == ST_XFER && !cmp_ok);
  c_cont: cover property (@(posedge mclk) disable iff (!rst_n) state_r == ST_XFER && sc1_r[conv_ctrl_pkg::SC1_CONT]);
  c_long: cover property (@(posedge mclk) disable iff (!rst_n) core_sample && lsmp);
endmodule : conv_ctrl

//--- sim/core_model.sv
// analog core stand-in: converts a level set by the bench
`timescale 1ns/100ps
module core_model (
  // clock
  input wire logic mclk,
  // sampling phase from the converter control
  input wire logic core_sample,
  // analog level chosen by the bench
  input wire logic [9:0] level,
  // conversion result
  output logic [9:0] core_data
);
  logic [9:0] held_r = 10'h155;
  // track the input while sampling; the level at the end of sampling is what gets converted
  always_ff @(posedge mclk) begin
    if (core_sample) begin
      held_r <= level;
    end
  end
  // no valid result while sampling, so show the inverse to expose an early transfer
  assign core_data = core_sample ? ~held_r : held_r;
endmodule : core_model

//--- sim/tb.sv
// testbench: axi4-lite register sequences against the converter control
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb;
  localparam int ACK = 4;
  localparam logic [1:0] OK = conv_ctrl_pkg::RESP_OK;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  int gap;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [9:0] level = 10'h000;
  logic awready, wready, bvalid, arready, rvalid, smp, cnv, lp, ack, done_irq;
  logic saw, ord_ok, lp_seen, ack_seen, bad;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [4:0] chan;
  logic [9:0] core_data, prev;
  logic [10:0] df;
  // conversion timing table: config value and worst-case length in mclk cycles
  logic [7:0] tcfg [5] = '{8'h00, 8'h08, 8'h10, 8'h98, 8'h0b};
  int tlim [5] = '{25, 28, 45, 48, 28 + ACK};
  // continuous period limits for the first four timing classes
  int plim [4] = '{17, 20, 37, 40};
  // abort sources: register and value written mid-conversion
  logic [7:0] aoff [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h1c};
  logic [7:0] aval [6] = '{8'h1f, 8'h00, 8'h08, 8'h00, 8'h00, 8'h01};
  // compare cases against a compare value of 0x200
  logic cgt [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  logic chit [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  logic [9:0] clv [6] = '{10'h080, 10'h250, 10'h250, 10'h100, 10'h200, 10'h300};
  logic [7:0] csc [6] = '{8'h41, 8'h41, 8'h41, 8'h41, 8'h41, 8'h01};

  conv_ctrl #(.ACK_START(ACK)) conv_ctrl_i (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .core_data(core_data), .channel_select(chan), .core_sample(smp), .core_convert(cnv),
    .low_power_select(lp), .internal_async_clock(ack), .done_irq(done_irq));
  core_model core_model_i (.mclk(mclk), .core_sample(smp), .level(level), .core_data(core_data));

  // 25 mhz clock
  always #20 mclk = ~mclk;

  // hang guard, well above the roughly 1600 cycles the sequence needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 10000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  // handshakes are judged at the negedge before the edge, where ready and valid are settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] rsp;
    b = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b) begin
      @(negedge mclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid === 1'b1;
      rsp = bresp;
      @(posedge mclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    `CHK("write resp", er, rsp)
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    logic ar, r;
    logic [31:0] d;
    logic [1:0] rs;
    r = 1'b0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r) begin
      @(negedge mclk);
      ar = arvalid && arready;
      r = rvalid === 1'b1;
      d = rdata;
      rs = rresp;
      @(posedge mclk);
      if (ar) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    `CHK("read data", {24'h000000, e}, d)
    `CHK("read resp", er, rs)
  endtask : rd

  // wait for the done interrupt, noting phase order and side outputs
  task automatic run(input int lim);
    int n;
    n = 0;
    saw = 1'b0;
    ord_ok = 1'b1;
    lp_seen = 1'b0;
    ack_seen = 1'b0;
    while (done_irq !== 1'b1 && n < lim) begin
      @(negedge mclk);
      n++;
      saw = saw | smp;
      ord_ok = ord_ok & (saw | !cnv);
      lp_seen = lp_seen | (smp & lp);
      ack_seen = ack_seen | ack;
    end
    @(posedge mclk);
  endtask : run

  // cycles until the next start of sampling
  task automatic rise(output int n);
    n = 0;
    while (smp !== 1'b0 && n < 300) @(negedge mclk) n++;
    while (smp !== 1'b1 && n < 300) @(negedge mclk) n++;
    @(posedge mclk);
  endtask : rise

  task automatic idle_chk();
    bad = 1'b0;
    repeat (60) @(negedge mclk) bad = bad | smp | cnv;
    @(posedge mclk);
    `CHK("stays idle", 1'b0, bad)
  endtask : idle_chk

  // reset for 16 cycles, then every register against its reset value
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    clk_en <= 1'b1;
    for (int i = 0; i < 8; i++) rd(8'(4 * i), (i == 0) ? conv_ctrl_pkg::SC1_RST : 8'h00, OK);
    `CHK("channel", 5'h1f, chan)
  endtask : do_reset

  initial begin
    do_reset();
    // single conversions in every timing class
    for (int i = 0; i < 5; i++) begin
      level <= 10'h2c5 - 10'(i * 37);
      wr(conv_ctrl_pkg::OFF_CFG, tcfg[i], OK);
      wr(conv_ctrl_pkg::OFF_SC1, 8'h41, OK);
      run(tlim[i]);
      `CHK("done in time", 1'b1, done_irq)
      `CHK("sample first", 1'b1, ord_ok)
      `CHK("low power", tcfg[i][7], lp_seen)
      `CHK("async clock", tcfg[i][1:0] == 2'h3, ack_seen)
      if (tcfg[i][3]) begin
        rd(conv_ctrl_pkg::OFF_RH, {6'h00, level[9:8]}, OK);
        rd(conv_ctrl_pkg::OFF_RL, level[7:0], OK);
      end
    end
    // continuous period in each length class, measured sample start to sample start
    for (int i = 0; i < 4; i++) begin
      wr(conv_ctrl_pkg::OFF_CFG, tcfg[i], OK);
      wr(conv_ctrl_pkg::OFF_SC1, 8'h21, OK);
      rise(gap);
      rise(gap);
      rise(gap);
      `CHK("continuous period", 1'b1, gap <= plim[i])
    end
    // each abort source mid-conversion; a new level is sampled so a missed abort shows in the result
    for (int i = 0; i < 6; i++) begin
      level <= 10'h1a6;
      wr(conv_ctrl_pkg::OFF_SC1, 8'h21, OK);
      rise(gap);
      rise(gap);
      level <= 10'h059;
      wr(aoff[i], aval[i], OK);
      if (i == 0) `CHK("channel off", 5'h1f, chan)
      wr(conv_ctrl_pkg::OFF_MISC, 8'h00, OK);
      idle_chk();
      rd(conv_ctrl_pkg::OFF_RH, 8'h01, OK);
      rd(conv_ctrl_pkg::OFF_RL, 8'ha6, OK);
    end
    // automatic compare, both limits, hit and miss, masked interrupt
    wr(conv_ctrl_pkg::OFF_CVH, 8'h02, OK);
    wr(conv_ctrl_pkg::OFF_CVL, 8'h00, OK);
    prev = 10'h1a6;
    for (int i = 0; i < 6; i++) begin
      df = {1'b0, clv[i]} - 11'h200;
      level <= clv[i];
      wr(conv_ctrl_pkg::OFF_SC2, {2'b00, 1'b1, cgt[i], 4'h0}, OK);
      wr(conv_ctrl_pkg::OFF_SC1, csc[i], OK);
      run(60);
      `CHK("irq", chit[i] & csc[i][6], done_irq)
      rd(conv_ctrl_pkg::OFF_SC1, {chit[i], csc[i][6:0]}, OK);
      if (chit[i]) prev = df[9:0];
      rd(conv_ctrl_pkg::OFF_RH, {6'h00, prev[9:8]}, OK);
      rd(conv_ctrl_pkg::OFF_RL, prev[7:0], OK);
    end
    // unmapped places answer with an error
    rd(8'h20, 8'h00, conv_ctrl_pkg::RESP_ERR);
    wr(8'h24, 8'h55, conv_ctrl_pkg::RESP_ERR);
    do_reset();
    print_verdict();
  end
endmodule : tb
